/* inc/mmsb_pkg.sv */
// Constants, states and register map of the bargraph meter menu block
// Function
// [R01] Program press advances one step on release
// [R02] Two-button command needs simultaneous press then release
// [R03] Up increments, down decrements edited value
// [R04] Display flashes function code against value
// [R05] Up/down cycle through selectable options
// [R06] Lamp test 3 s, version 2 s, then run
// [R07] Offset range -1999..9999, default zero
// [R08] Scale default 2000, range -1999..9999
// [R09] Reading equals scale times volts/2 plus offset
// [R10] Overrange outside -1 V to +2 V
// [R11] Program+up shows calibration prompt, off/on toggles
// [R12] No analog output: skip to scale entry
// [R13] Input calibration choice leads to offset entry
// [R14] Program stores offset, then scale entry
// [R15] Scale commit leads to bargraph high entry
// [R16] Bargraph 0..101 bars, span 100..12000 counts
// [R17] Bars from low to high point; flash above
// [R18] Program at calibration off enters bargraph high
// [R19] Bargraph high commit leads to bargraph low
// [R20] Positive overrange flashes bargraph and top segments
// [R21] Negative overrange flashes first bar, bottom segments
// [R22] Buttons synchronised and debounced before edges
// [R23] Edits clamped, committed only on program press
package mmsb_pkg;
  // Clock and times
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned LAMP_MS = 3000;
  localparam int unsigned VER_MS = 2000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned FLASH_MS = 500;
  // Value limits and defaults
  localparam logic signed [15:0] VAL_MIN = -16'sd1999;
  localparam logic signed [15:0] VAL_MAX = 16'sd9999;
  localparam logic signed [15:0] OFFSET_RST = 16'sd0;
  localparam logic signed [15:0] SCALE_RST = 16'sd2000;
  localparam logic signed [15:0] BHI_RST = 16'sd2000;
  localparam logic signed [15:0] BAR_LO_RST = 16'sd0;
  localparam logic signed [31:0] SPAN_MIN = 32'sd100;
  localparam logic signed [31:0] SPAN_MAX = 32'sd12000;
  localparam logic [6:0] BAR_FULL = 7'h65;
  localparam logic [6:0] BAR_FIRST = 7'h01;
  // Input span in millivolts, gain divisor (2 x 1000 mV)
  localparam logic signed [15:0] IN_MIN_MV = -16'sd1000;
  localparam logic signed [15:0] IN_MAX_MV = 16'sd2000;
  localparam logic signed [31:0] GAIN_DIV = 32'sd2000;
  // Register byte offsets
  localparam logic [4:0] REG_OFFSET = 5'h00;
  localparam logic [4:0] REG_SCALE = 5'h04;
  localparam logic [4:0] REG_BAR_HI = 5'h08;
  localparam logic [4:0] REG_BAR_LO = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_READING = 5'h14;
  // Status field positions
  localparam int unsigned ST_OVR_POS_BIT = 16;
  localparam int unsigned ST_OVR_NEG_BIT = 17;
  localparam int unsigned ST_AOUT_BIT = 18;
  // Display modes
  typedef enum logic [1:0] {
    DM_VALUE = 2'h0, DM_CODE = 2'h1, DM_ALL_ON = 2'h2, DM_VERSION = 2'h3
  } mmsb_disp_t;
  // Prompt codes shown in code mode
  typedef enum logic [3:0] {
    PC_NONE = 4'h0, PC_CAL = 4'h1, PC_CAL_CHOICE = 4'h2,
    PC_ZERO_READING = 4'h3, PC_GAIN = 4'h4, PC_BAR_HIGH = 4'h5,
    PC_BAR_SPAN_LOW = 4'h6
  } mmsb_code_t;
  // Menu states, one-hot
  typedef enum logic [9:0] {
    ST_LAMP = 10'h001, ST_VER = 10'h002, ST_RUN = 10'h004,
    ST_CAL = 10'h008, ST_CHOICE = 10'h010, ST_ZERO = 10'h020,
    ST_GAIN = 10'h040, ST_BHI = 10'h080, ST_BAR_LO = 10'h100,
    ST_SPARE = 10'h200
  } mmsb_state_t;
endpackage : mmsb_pkg

/* verilog/mmsb_meter.sv */
// Menu state machine, rescaling and bargraph mapping of the panel meter
`timescale 1ns/100ps
module mmsb_meter #(
  parameter int unsigned LAMP_CYC = mmsb_pkg::LAMP_MS * mmsb_pkg::CLK_KHZ,
  parameter int unsigned VER_CYC = mmsb_pkg::VER_MS * mmsb_pkg::CLK_KHZ,
  parameter int unsigned DEB_CYC =
    mmsb_pkg::DEBOUNCE_MS * mmsb_pkg::CLK_KHZ,
  parameter int unsigned FLASH_CYC = mmsb_pkg::FLASH_MS * mmsb_pkg::CLK_KHZ,
  parameter logic [15:0] VERSION = 16'h0101 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Front panel buttons, pins, high while pressed
  input wire logic btn_prog_i,
  input wire logic btn_up_i,
  input wire logic btn_down_i,
  // Analog output module present, pin
  input wire logic aout_present_i,
  // Converter samples in millivolts
  input wire logic signed [15:0] sample_mv_i,
  input wire logic sample_valid_i,
  // Numeric display
  output logic [1:0] disp_mode_o,
  output logic [3:0] disp_code_o,
  output logic signed [15:0] disp_value_o,
  output logic digit_top_flash_o,
  output logic digit_bot_flash_o,
  // Bargraph
  output logic [6:0] bar_count_o,
  output logic bar_flash_o,
  // Menu state
  output logic [9:0] menu_state_o
);

  localparam int unsigned BTN_PROG = 0;
  localparam int unsigned BTN_UP = 1;
  localparam int unsigned BTN_DOWN = 2;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic aout1;
    logic aout2;
    logic [2:0] stable;
    logic [2:0][31:0] deb_cnt;
    logic [2:0] held;
    mmsb_pkg::mmsb_state_t state;
    logic [31:0] timer;
    logic [31:0] flash_cnt;
    logic flash_ph;
    logic opt;
    logic signed [15:0] edit;
    logic signed [15:0] offset;
    logic signed [15:0] scale;
    logic signed [15:0] bhi;
    logic signed [15:0] lo_pt;
    logic signed [31:0] reading;
    logic ovr_pos;
    logic ovr_neg;
    logic [6:0] bar;
    logic bar_flash;
    logic [1:0] disp_mode;
    logic [3:0] disp_code;
    logic signed [15:0] disp_value;
    logic top_flash;
    logic bot_flash;
    logic wait_n;
    logic [31:0] rdata;
  } mmsb_st_t;

  mmsb_st_t r_reg;
  mmsb_st_t r_next;
  logic ev_prog;
  logic ev_up;
  logic ev_down;
  logic ev_cal;

  // Saturate any value into the editable range
  function automatic logic signed [15:0] clamp(
    input logic signed [31:0] v);
    logic signed [15:0] res;
    res = v[15:0];
    if (v < 32'(mmsb_pkg::VAL_MIN)) begin
      res = mmsb_pkg::VAL_MIN;
    end else if (v > 32'(mmsb_pkg::VAL_MAX)) begin
      res = mmsb_pkg::VAL_MAX;
    end
    return res;
  endfunction : clamp

  // Next-state logic for the whole block
  always_comb begin
    logic [2:0] released;
    logic signed [31:0] prod;
    logic signed [31:0] span;
    logic signed [31:0] rel_pos;
    logic signed [31:0] bar_full;
    logic editing;
    released = 3'h0;
    prod = 32'sd0;
    span = 32'sd0;
    rel_pos = 32'sd0;
    bar_full = 32'sd0;
    editing = 1'b0;
    r_next = r_reg;

    // Two-stage synchronisers on every pin input [R22]
    r_next.sync1 = {btn_down_i, btn_up_i, btn_prog_i};
    r_next.sync2 = r_reg.sync1;
    r_next.aout1 = aout_present_i;
    r_next.aout2 = r_reg.aout1;

    // Debounce: level must hold DEB_CYC cycles before it is taken [R22]
    for (int i = 0; i < 3; i++) begin
      if (r_reg.sync2[i] != r_reg.stable[i]) begin
        r_next.deb_cnt[i] = r_reg.deb_cnt[i] + 32'h1;
        if (r_reg.deb_cnt[i] == DEB_CYC - 1) begin
          r_next.stable[i] = r_reg.sync2[i];
          r_next.deb_cnt[i] = 32'h0;
        end
      end else begin
        r_next.deb_cnt[i] = 32'h0;
      end
    end

    // Collect buttons held since the first press; decide on full release
    if (r_reg.held != 3'h0 && r_next.stable == 3'h0) begin
      released = r_reg.held; // [R01] [R02]
      r_next.held = 3'h0;
    end else begin
      r_next.held = r_reg.held | r_next.stable;
    end
    ev_prog = released == 3'h1;
    ev_up = released == 3'h2;
    ev_down = released == 3'h4;
    ev_cal = released == 3'h3; // Program and up together [R02]

    // Flash phase for code against value
    r_next.flash_cnt = r_reg.flash_cnt + 32'h1;
    if (r_reg.flash_cnt == FLASH_CYC - 1) begin
      r_next.flash_cnt = 32'h0;
      r_next.flash_ph = ~r_reg.flash_ph;
    end

    // Value editing; clamped, commit happens only on program [R03] [R23]
    editing = r_reg.state == mmsb_pkg::ST_ZERO ||
      r_reg.state == mmsb_pkg::ST_GAIN ||
      r_reg.state == mmsb_pkg::ST_BHI || r_reg.state == mmsb_pkg::ST_BAR_LO;
    if (editing && ev_up) begin
      r_next.edit = clamp(32'(r_reg.edit) + 32'sd1); // [R03] [R23]
    end else if (editing && ev_down) begin
      r_next.edit = clamp(32'(r_reg.edit) - 32'sd1); // [R03] [R23]
    end

    // Menu state machine
    r_next.timer = 32'h0;
    case (r_reg.state)
      mmsb_pkg::ST_LAMP: begin
        r_next.timer = r_reg.timer + 32'h1;
        if (r_reg.timer == LAMP_CYC - 1) begin // [R06]
          r_next.state = mmsb_pkg::ST_VER;
          r_next.timer = 32'h0;
        end
      end
      mmsb_pkg::ST_VER: begin
        r_next.timer = r_reg.timer + 32'h1;
        if (r_reg.timer == VER_CYC - 1) begin // [R06]
          r_next.state = mmsb_pkg::ST_RUN;
          r_next.timer = 32'h0;
        end
      end
      mmsb_pkg::ST_RUN: begin
        if (ev_cal) begin // [R11]
          r_next.state = mmsb_pkg::ST_CAL;
          r_next.opt = 1'b0;
        end
      end
      mmsb_pkg::ST_CAL: begin
        if (ev_up || ev_down) begin
          r_next.opt = ~r_reg.opt; // Off against on [R11] [R05]
        end else if (ev_prog && !r_reg.opt) begin
          r_next.state = mmsb_pkg::ST_BHI; // [R18]
          r_next.edit = r_reg.bhi;
        end else if (ev_prog && r_reg.aout2) begin
          r_next.state = mmsb_pkg::ST_CHOICE; // [R11]
          r_next.opt = 1'b0;
        end else if (ev_prog) begin
          r_next.state = mmsb_pkg::ST_GAIN; // [R12]
          r_next.edit = r_reg.scale;
        end
      end
      mmsb_pkg::ST_CHOICE: begin
        if (ev_up || ev_down) begin
          r_next.opt = ~r_reg.opt; // Output against input cal [R05] [R13]
        end else if (ev_prog && r_reg.opt) begin
          r_next.state = mmsb_pkg::ST_ZERO; // [R13]
          r_next.edit = r_reg.offset;
        end else if (ev_prog) begin
          // Output calibration is not held here; back to the reading
          r_next.state = mmsb_pkg::ST_RUN;
        end
      end
      mmsb_pkg::ST_ZERO: begin
        if (ev_prog) begin
          r_next.offset = r_reg.edit; // [R14] [R07]
          r_next.state = mmsb_pkg::ST_GAIN;
          r_next.edit = r_reg.scale;
        end
      end
      mmsb_pkg::ST_GAIN: begin
        if (ev_prog) begin
          r_next.scale = r_reg.edit; // [R15] [R08]
          r_next.state = mmsb_pkg::ST_BHI;
          r_next.edit = r_reg.bhi;
        end
      end
      mmsb_pkg::ST_BHI: begin
        if (ev_prog) begin
          r_next.bhi = r_reg.edit; // [R19]
          r_next.state = mmsb_pkg::ST_BAR_LO;
          r_next.edit = r_reg.lo_pt;
        end
      end
      mmsb_pkg::ST_BAR_LO: begin
        if (ev_prog) begin
          // Low point kept at least the minimum span below high [R16]
          if (32'(r_reg.edit) > 32'(r_reg.bhi) - mmsb_pkg::SPAN_MIN) begin
            r_next.lo_pt = clamp(32'(r_reg.bhi) - mmsb_pkg::SPAN_MIN);
          end else begin
            r_next.lo_pt = r_reg.edit;
          end
          r_next.state = mmsb_pkg::ST_RUN;
        end
      end
      default: begin
        r_next.state = mmsb_pkg::ST_RUN;
      end
    endcase

    // Software writes reach parameters only from the operational display;
    // a write lands at the answer edge, while waitrequest is low
    if (avs_write_i && r_reg.wait_n && r_reg.state == mmsb_pkg::ST_RUN) begin
      case (avs_address_i)
        mmsb_pkg::REG_OFFSET: begin
          r_next.offset = clamp(32'(signed'(avs_writedata_i[15:0])));
        end
        mmsb_pkg::REG_SCALE: begin
          r_next.scale = clamp(32'(signed'(avs_writedata_i[15:0])));
        end
        mmsb_pkg::REG_BAR_HI: begin
          r_next.bhi = clamp(32'(signed'(avs_writedata_i[15:0])));
        end
        mmsb_pkg::REG_BAR_LO: begin
          r_next.lo_pt = clamp(32'(signed'(avs_writedata_i[15:0])));
        end
        default: begin
        end
      endcase
    end

    // Rescale: reading = scale * mV / 2000 + offset [R09]
    if (sample_valid_i) begin
      prod = 32'(r_reg.scale) * 32'(sample_mv_i);
      r_next.reading = prod / mmsb_pkg::GAIN_DIV + 32'(r_reg.offset);
      r_next.ovr_pos = sample_mv_i > mmsb_pkg::IN_MAX_MV ||
        prod / mmsb_pkg::GAIN_DIV + 32'(r_reg.offset) >
        32'(mmsb_pkg::VAL_MAX); // [R10] [R17]
      r_next.ovr_neg = sample_mv_i < mmsb_pkg::IN_MIN_MV ||
        prod / mmsb_pkg::GAIN_DIV + 32'(r_reg.offset) <
        32'(mmsb_pkg::VAL_MIN); // [R10]
    end

    // Bargraph mapping between low and high points [R16] [R17]
    span = 32'(r_reg.bhi) - 32'(r_reg.lo_pt);
    if (span < mmsb_pkg::SPAN_MIN) begin
      span = mmsb_pkg::SPAN_MIN;
    end else if (span > mmsb_pkg::SPAN_MAX) begin
      span = mmsb_pkg::SPAN_MAX;
    end
    bar_full = 32'(mmsb_pkg::BAR_FULL);
    rel_pos = ((r_reg.reading - 32'(r_reg.lo_pt)) * bar_full) / span;
    r_next.bar_flash = 1'b0;
    if (r_reg.ovr_pos) begin
      r_next.bar = mmsb_pkg::BAR_FULL; // [R20]
      r_next.bar_flash = 1'b1;
    end else if (r_reg.ovr_neg) begin
      r_next.bar = mmsb_pkg::BAR_FIRST; // [R21]
      r_next.bar_flash = 1'b1;
    end else if (r_reg.reading <= 32'(r_reg.lo_pt)) begin
      r_next.bar = 7'h00;
    end else if (r_reg.reading >= 32'(r_reg.bhi)) begin
      r_next.bar = mmsb_pkg::BAR_FULL; // [R17]
      r_next.bar_flash = r_reg.reading > 32'(r_reg.bhi);
    end else begin
      r_next.bar = rel_pos[6:0];
    end
    r_next.top_flash = r_reg.ovr_pos; // [R20]
    r_next.bot_flash = r_reg.ovr_neg; // [R21]

    // Numeric display source; prompts flash against values [R04]
    r_next.disp_mode = mmsb_pkg::DM_VALUE;
    r_next.disp_code = mmsb_pkg::PC_NONE;
    r_next.disp_value = r_reg.edit;
    case (r_reg.state)
      mmsb_pkg::ST_LAMP: r_next.disp_mode = mmsb_pkg::DM_ALL_ON; // [R06]
      mmsb_pkg::ST_VER: begin
        r_next.disp_mode = mmsb_pkg::DM_VERSION;
        r_next.disp_value = VERSION;
      end
      mmsb_pkg::ST_RUN: r_next.disp_value = clamp(r_reg.reading);
      mmsb_pkg::ST_CAL: begin
        r_next.disp_code = mmsb_pkg::PC_CAL;
        r_next.disp_value = {15'h0000, r_reg.opt};
      end
      mmsb_pkg::ST_CHOICE: begin
        r_next.disp_code = mmsb_pkg::PC_CAL_CHOICE;
        r_next.disp_value = {15'h0000, r_reg.opt};
      end
      mmsb_pkg::ST_ZERO: r_next.disp_code = mmsb_pkg::PC_ZERO_READING;
      mmsb_pkg::ST_GAIN: r_next.disp_code = mmsb_pkg::PC_GAIN;
      mmsb_pkg::ST_BHI: r_next.disp_code = mmsb_pkg::PC_BAR_HIGH;
      mmsb_pkg::ST_BAR_LO: r_next.disp_code = mmsb_pkg::PC_BAR_SPAN_LOW;
      default: r_next.disp_value = clamp(r_reg.reading);
    endcase
    if (r_next.disp_code != mmsb_pkg::PC_NONE && r_reg.flash_ph) begin
      r_next.disp_mode = mmsb_pkg::DM_CODE; // [R04]
    end

    // Bus: one wait cycle, then a single-cycle answer
    r_next.wait_n = (avs_read_i || avs_write_i) && !r_reg.wait_n;
    r_next.rdata = 32'h0;
    if (avs_read_i && !r_reg.wait_n) begin
      case (avs_address_i)
        mmsb_pkg::REG_OFFSET: r_next.rdata = 32'(r_reg.offset);
        mmsb_pkg::REG_SCALE: r_next.rdata = 32'(r_reg.scale);
        mmsb_pkg::REG_BAR_HI: r_next.rdata = 32'(r_reg.bhi);
        mmsb_pkg::REG_BAR_LO: r_next.rdata = 32'(r_reg.lo_pt);
        mmsb_pkg::REG_STATUS: begin
          r_next.rdata[9:0] = r_reg.state;
          r_next.rdata[mmsb_pkg::ST_OVR_POS_BIT] = r_reg.ovr_pos;
          r_next.rdata[mmsb_pkg::ST_OVR_NEG_BIT] = r_reg.ovr_neg;
          r_next.rdata[mmsb_pkg::ST_AOUT_BIT] = r_reg.aout2;
        end
        mmsb_pkg::REG_READING: r_next.rdata = r_reg.reading;
        default: r_next.rdata = 32'h0;
      endcase
    end
  end

  // State register; constants only under reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
      r_reg.state <= mmsb_pkg::ST_LAMP;
      r_reg.offset <= mmsb_pkg::OFFSET_RST; // [R07]
      r_reg.scale <= mmsb_pkg::SCALE_RST; // [R08]
      r_reg.bhi <= mmsb_pkg::BHI_RST;
      r_reg.lo_pt <= mmsb_pkg::BAR_LO_RST;
      r_reg.disp_mode <= mmsb_pkg::DM_ALL_ON;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata_o = r_reg.rdata;
  assign avs_waitrequest_o = !r_reg.wait_n;
  assign disp_mode_o = r_reg.disp_mode;
  assign disp_code_o = r_reg.disp_code;
  assign disp_value_o = r_reg.disp_value;
  assign digit_top_flash_o = r_reg.top_flash;
  assign digit_bot_flash_o = r_reg.bot_flash;
  assign bar_count_o = r_reg.bar;
  assign bar_flash_o = r_reg.bar_flash;
  assign menu_state_o = r_reg.state;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_lamp_end;
    r_reg.state == mmsb_pkg::ST_LAMP && r_reg.timer == LAMP_CYC - 1
      |=> r_reg.state == mmsb_pkg::ST_VER ##1
      r_reg.disp_mode == mmsb_pkg::DM_VERSION;
  endproperty
  a_lamp_end: assert property (p_lamp_end) // [R06]
    else $error("lamp test did not hand over to version");

  property p_ver_end;
    r_reg.state == mmsb_pkg::ST_VER && r_reg.timer == VER_CYC - 1
      |=> r_reg.state == mmsb_pkg::ST_RUN;
  endproperty
  a_ver_end: assert property (p_ver_end) // [R06]
    else $error("version display did not end in run");

  property p_cal_entry;
    r_reg.state == mmsb_pkg::ST_RUN && ev_cal
      |=> r_reg.state == mmsb_pkg::ST_CAL && !r_reg.opt;
  endproperty
  a_cal_entry: assert property (p_cal_entry) // [R02]
    else $error("two-button press did not enter calibration");

  property p_zero_commit;
    r_reg.state == mmsb_pkg::ST_ZERO && ev_prog |=>
      r_reg.state == mmsb_pkg::ST_GAIN &&
      r_reg.offset == $past(r_reg.edit) && r_reg.edit == r_reg.scale;
  endproperty
  a_zero_commit: assert property (p_zero_commit) // [R14]
    else $error("offset not committed on program press");

  property p_inc;
    (r_reg.state == mmsb_pkg::ST_GAIN ||
      r_reg.state == mmsb_pkg::ST_BHI) && ev_up &&
      r_reg.edit < mmsb_pkg::VAL_MAX |=> r_reg.edit == $past(r_reg.edit) + 1;
  endproperty
  a_inc: assert property (p_inc) // [R03]
    else $error("up press did not increment");

  property p_edit_range;
    r_reg.edit >= mmsb_pkg::VAL_MIN && r_reg.edit <= mmsb_pkg::VAL_MAX;
  endproperty
  a_edit_range: assert property (p_edit_range) // [R23]
    else $error("edited value out of range");

  property p_ovr;
    sample_valid_i && sample_mv_i > mmsb_pkg::IN_MAX_MV
      |=> r_reg.ovr_pos ##1 bar_count_o == mmsb_pkg::BAR_FULL && bar_flash_o;
  endproperty
  a_ovr: assert property (p_ovr) // [R20]
    else $error("positive overrange not shown");

  property p_bus;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not after one wait cycle");

endmodule : mmsb_meter

/* tb/mmsb_panel.sv */
// Front panel push-button model driving the meter's button pins
`timescale 1ns/100ps
module mmsb_panel (
  // Clock
  input wire logic clk_i,
  // Button pins, high while pressed
  output logic btn_prog_o,
  output logic btn_up_o,
  output logic btn_down_o
);
  // Released at power-up
  initial begin
    btn_prog_o = 1'b0;
    btn_up_o = 1'b0;
    btn_down_o = 1'b0;
  end
  // Set {prog,up,down} together, just after an edge
  task automatic press(input logic [2:0] m);
    @(posedge clk_i);
    {btn_prog_o, btn_up_o, btn_down_o} <= m;
  endtask : press
  // Press, hold, release all together, rest; hold of 1 is a bounce
  task automatic push(input logic [2:0] m, input int hold);
    press(m);
    repeat (hold) @(posedge clk_i);
    press(3'h0);
    repeat (hold) @(posedge clk_i);
  endtask : push
endmodule : mmsb_panel

/* tb/mmsb_meter_tb.sv */
// Self-checking bench of the bargraph meter menu block
`timescale 1ns/100ps
module mmsb_meter_tb;
  logic clk_i = 1'b0;
  logic nrst_i;
  logic [4:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic wreq;
  logic bp;
  logic bu;
  logic bd;
  logic aout;
  logic signed [15:0] smv;
  logic sval;
  logic [1:0] dmode;
  logic [3:0] dcode;
  logic signed [15:0] dval;
  logic tfl;
  logic bfl;
  logic [6:0] bars;
  logic barfl;
  logic [9:0] st;
  logic [31:0] q;
  int error_cnt = 0;
  int num_checks = 0;

  // Short counts keep the power-up and debounce quick
  mmsb_meter #(.LAMP_CYC(40), .VER_CYC(30), .DEB_CYC(4), .FLASH_CYC(8))
    mmsb_meter_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .btn_prog_i(bp), .btn_up_i(bu),
    .btn_down_i(bd), .aout_present_i(aout), .sample_mv_i(smv),
    .sample_valid_i(sval), .disp_mode_o(dmode), .disp_code_o(dcode),
    .disp_value_o(dval), .digit_top_flash_o(tfl),
    .digit_bot_flash_o(bfl), .bar_count_o(bars), .bar_flash_o(barfl),
    .menu_state_o(st));
  mmsb_panel mmsb_panel_inst (.clk_i(clk_i), .btn_prog_o(bp),
    .btn_up_o(bu), .btn_down_o(bd));

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  // One Avalon cycle; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      chk("bus answer", 1'b0, 1'b1);
  endtask : bus
  task automatic wait_st(input logic [9:0] s);
    int n;
    n = 0;
    while (st !== s && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("menu state", st, s);
  endtask : wait_st
  // Waiting for a mode also proves the display alternates in time
  task automatic wait_md(input logic [1:0] m);
    int n;
    n = 0;
    while (dmode !== m && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("display mode", dmode, m);
  endtask : wait_md
  task automatic smp(input logic signed [15:0] mv);
    @(posedge clk_i);
    smv <= mv;
    sval <= !sval; // One-cycle strobe from idle low
    @(posedge clk_i);
    sval <= !sval;
    repeat (3) @(posedge clk_i);
  endtask : smp
  task automatic prompt(input logic [3:0] c, input logic [31:0] v);
    wait_md(mmsb_pkg::DM_CODE);
    chk("prompt", dcode, c);
    wait_md(mmsb_pkg::DM_VALUE);
    chk("shown value", dval, v);
  endtask : prompt

  task automatic t_power;
    int n;
    n = 0;
    chk("lamp mode", dmode, mmsb_pkg::DM_ALL_ON);
    while (st === mmsb_pkg::ST_LAMP && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    chk("lamp length", n >= 38 && n <= 42, 1'b1);
    // Display mode follows the state one edge later
    @(posedge clk_i);
    chk("version mode", dmode, mmsb_pkg::DM_VERSION);
    chk("version", dval, 32'h101);
    n = 0;
    while (st === mmsb_pkg::ST_VER && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    chk("version length", n >= 28 && n <= 32, 1'b1);
    chk("run state", st, mmsb_pkg::ST_RUN);
    $display("power-up sequence done");
  endtask : t_power
  task automatic t_regs;
    bus(1'b0, 5'h00, 32'h0);
    chk("offset default", q, 32'h0);
    bus(1'b0, 5'h04, 32'h0);
    chk("scale default", q, 32'h7d0);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, 5'h00, 32'h4e20);
    bus(1'b0, 5'h00, 32'h0);
    chk("offset clamp", q, 32'h270f);
    bus(1'b1, 5'h04, 32'hffffec78);
    bus(1'b0, 5'h04, 32'h0);
    chk("scale clamp", q, 32'hfffff831);
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h04, 32'h7d0);
    $display("register test done");
  endtask : t_regs
  task automatic t_read;
    smp(16'h7d0);
    bus(1'b0, 5'h14, 32'h0);
    chk("reading 2V", q, 32'h7d0);
    chk("bars full", {bars, barfl}, {7'h65, 1'b0});
    smp(16'h0);
    chk("bars empty", bars, 7'h0);
    smp(16'h7d1);
    bus(1'b0, 5'h10, 32'h0);
    chk("ovr pos", q[17:16], 2'b01);
    chk("pos flash", {tfl, barfl, bars}, {2'b11, 7'h65});
    smp(16'hfc17);
    bus(1'b0, 5'h10, 32'h0);
    chk("ovr neg", q[17:16], 2'b10);
    chk("neg flash", {bfl, barfl, bars}, {2'b11, 7'h01});
    bus(1'b1, 5'h04, 32'hbb8);
    bus(1'b1, 5'h00, 32'h14);
    smp(16'h5dc);
    bus(1'b0, 5'h14, 32'h0);
    chk("reading scaled", q, 32'h8de);
    chk("above high", {tfl, barfl, bars}, {2'b01, 7'h65});
    chk("digits", dval, 32'h8de);
    bus(1'b1, 5'h04, 32'h7d0);
    bus(1'b1, 5'h00, 32'h0);
    $display("reading test done");
  endtask : t_read
  task automatic t_cal_bare;
    // Output module absent: pin still low from the start
    mmsb_panel_inst.push(3'b110, 12);
    wait_st(mmsb_pkg::ST_CAL);
    prompt(mmsb_pkg::PC_CAL, 32'h0);
    mmsb_panel_inst.push(3'b010, 12);
    prompt(mmsb_pkg::PC_CAL, 32'h1);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_GAIN);
    prompt(mmsb_pkg::PC_GAIN, 32'h7d0);
    mmsb_panel_inst.push(3'b100, 1);
    repeat (20) @(posedge clk_i);
    chk("bounce", st, mmsb_pkg::ST_GAIN);
    mmsb_panel_inst.press(3'b100);
    repeat (20) @(posedge clk_i);
    chk("held", st, mmsb_pkg::ST_GAIN);
    mmsb_panel_inst.press(3'b000);
    wait_st(mmsb_pkg::ST_BHI);
    prompt(mmsb_pkg::PC_BAR_HIGH, 32'h7d0);
    mmsb_panel_inst.push(3'b010, 12);
    mmsb_panel_inst.push(3'b010, 12);
    mmsb_panel_inst.push(3'b001, 12);
    prompt(mmsb_pkg::PC_BAR_HIGH, 32'h7d1);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_BAR_LO);
    prompt(mmsb_pkg::PC_BAR_SPAN_LOW, 32'h0);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_RUN);
    bus(1'b0, 5'h08, 32'h0);
    chk("bar high kept", q, 32'h7d1);
    bus(1'b1, 5'h08, 32'h7d0);
    $display("calibration without output done");
  endtask : t_cal_bare
  task automatic t_cal_aout;
    aout <= !aout; // Output module now fitted
    mmsb_panel_inst.push(3'b110, 12);
    wait_st(mmsb_pkg::ST_CAL);
    mmsb_panel_inst.push(3'b001, 12);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_CHOICE);
    prompt(mmsb_pkg::PC_CAL_CHOICE, 32'h0);
    mmsb_panel_inst.push(3'b010, 12);
    prompt(mmsb_pkg::PC_CAL_CHOICE, 32'h1);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_ZERO);
    prompt(mmsb_pkg::PC_ZERO_READING, 32'h0);
    mmsb_panel_inst.push(3'b001, 12);
    mmsb_panel_inst.push(3'b001, 12);
    prompt(mmsb_pkg::PC_ZERO_READING, 32'hfffffffe);
    bus(1'b0, 5'h00, 32'h0);
    chk("offset uncommitted", q, 32'h0);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_GAIN);
    prompt(mmsb_pkg::PC_GAIN, 32'h7d0);
    bus(1'b0, 5'h00, 32'h0);
    chk("offset stored", q, 32'hfffffffe);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_BHI);
    mmsb_panel_inst.push(3'b100, 12);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_RUN);
    $display("calibration with output done");
  endtask : t_cal_aout
  task automatic t_cal_bar;
    mmsb_panel_inst.push(3'b110, 12);
    wait_st(mmsb_pkg::ST_CAL);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_BHI);
    prompt(mmsb_pkg::PC_BAR_HIGH, 32'h7d0);
    mmsb_panel_inst.push(3'b100, 12);
    mmsb_panel_inst.push(3'b100, 12);
    wait_st(mmsb_pkg::ST_RUN);
    $display("bargraph submenu done");
  endtask : t_cal_bar

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    nrst_i = 1'b0;
    adr = 5'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    aout = 1'b0;
    smv = 16'sh0;
    sval = 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_power;
    t_regs;
    t_read;
    t_cal_bare;
    t_cal_aout;
    t_cal_bar;
    wrap_up;
  end
  // Watchdog at 25000 cycles, far beyond the roughly 1000 cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up;
  end
endmodule : mmsb_meter_tb
